// [core/seq_control.sv]
// sequence length, result placement and freeze control of the converter
// assumes conversion done pulses come from converter logic on the same clock
//
// Operation
// (RL1) any write to sequence_control aborts the running sequence, starts nothing
// (RL2) length from bits 6:3, 1..15 binary, zero means 16
// (RL3) after reset length field is four
// (RL4) queue off: nth result into nth register, up to length
// (RL5) queue on: counter not reset at sequence start or end
// (RL6) queue on with scan: counter wraps after last register
// (RL7) conversion counter readable as four-bit status field
// (RL8) abort or control write clears counter even in queue mode
// (RL9) per-register complete flags show which registers hold data
// (RL10) bits 1:0 select breakpoint response
// (RL11) 00 continue, 01 reserved, 10 finish then halt, 11 halt now
// (RL12) software should use queue mode with scan or triggered conversion
// (RL13) bit 7 reads zero, writes ignored
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ns
module seq_control
    import seq_pkg::*;
#(
    parameter int RESULTS = 16
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         reset,
    // register port
    input  wire logic [3:0]   addr,
    input  wire logic [15:0]  wdata,
    input  wire logic         wr_en,
    input  wire logic         rd_en,
    output logic      [15:0]  rdata,
    // converter side
    input  wire logic         other_ctrl_write,
    input  wire logic         triggered_conversion,
    input  wire logic         conv_done,
    input  wire logic [15:0]  result_read,
    input  wire logic         freeze,
    output logic              conv_active,
    output result_slot_t      result_slot,
    // interrupt
    output logic              irq
);
    // the counter and flag vectors are four and sixteen bits wide; refuse anything else
    if (RESULTS != 16) begin : g_results_check
        $error("seq_control serves exactly 16 result registers");
    end

    typedef struct packed {
        seq_state_t  state;
        logic [6:0]  ctrl;
        logic        scan;
        logic [3:0]  counter;
        logic [4:0]  done_in_seq;
        logic [15:0] complete;
        logic [2:0]  irq_status;
        logic [2:0]  irq_mask;
        logic        active;
        result_slot_t slot;
        logic [15:0] rdata;
        logic        irq;
    } state_t;

    state_t q, d;

    // ==========================================================
    // decoded fields
    logic [4:0]    len;
    logic          queue;
    freeze_mode_t  brk_resp;
    logic          wr_seq, wr_run, abort_ev, start_ev;
    logic          halted_now;
    assign len    = seq_length(q.ctrl[LEN_MSB:LEN_LSB]);          // see (RL2)
    assign queue  = q.ctrl[QUEUE_BIT];
    assign brk_resp = freeze_mode_t'(q.ctrl[RESP_MSB:RESP_LSB]);  // see (RL10)
    // reserved response code behaves as continue
    assign halted_now = freeze && brk_resp == BRK_NOW;
    assign wr_seq = wr_en && addr == ADDR_SEQUENCE_CONTROL;
    assign wr_run = wr_en && addr == ADDR_RUN_CONTROL;
    // writes to sequence_control or another control register abort, as does the run abort bit; only the run register can start
    assign abort_ev = wr_seq || other_ctrl_write ||
                      (wr_run && wdata[RUN_ABORT_BIT]);            // see (RL1)
    assign start_ev = wr_run && wdata[RUN_START_BIT] && !wdata[RUN_ABORT_BIT];

    // ==========================================================
    // next state
    always_comb begin
        logic        halted;
        logic [15:0] set_c;
        logic [2:0]  ev;
        halted = 1'b0;
        set_c  = 16'h0;
        ev     = 3'h0;
        d      = q;
        d.slot.valid = 1'b0;
        // freeze: reserved code behaves as continue
        if (freeze && brk_resp == BRK_NOW) halted = 1'b1;          // see (RL11)
        case (q.state)
            ST_IDLE: begin
                if (triggered_conversion) begin
                    d.state       = ST_CONV;
                    d.done_in_seq = 5'h0;
                    if (!queue) d.counter = 4'h0;                  // see (RL5)
                end
            end
            ST_CONV: begin
                if (halted) begin
                    d.state = ST_HALT;
                end else if (conv_done) begin
                    d.slot.valid  = 1'b1;
                    d.slot.index  = q.counter;
                    set_c[q.counter] = 1'b1;                       // see (RL9)
                    if (q.complete[q.counter]) ev[IRQ_OVERRUN] = 1'b1;
                    ev[IRQ_CONV_DONE] = 1'b1;
                    d.counter     = q.counter + 4'h1;              // see (RL6)
                    d.done_in_seq = q.done_in_seq + 5'h1;
                    if (q.done_in_seq + 5'h1 == len) begin
                        ev[IRQ_SEQ_DONE] = 1'b1;
                        d.done_in_seq = 5'h0;
                        if (!queue) d.counter = 4'h0;              // see (RL4)
                        if (!q.scan) d.state = ST_IDLE;
                    end
                    if (freeze && brk_resp == BRK_FINISH) d.state = ST_HALT; // see (RL11)
                end
            end
            ST_HALT: begin
                if (!freeze) d.state = ST_CONV;
            end
            default: d.state = ST_IDLE;
        endcase
        // control writes win over sequence progress
        if (abort_ev || start_ev) begin
            d.counter     = 4'h0;                                  // see (RL8)
            d.done_in_seq = 5'h0;
            d.state       = start_ev ? ST_CONV : ST_IDLE;
            d.slot.valid  = 1'b0;
        end
        if (wr_seq) d.ctrl = wdata[6:0] & SEQ_CTRL_WMASK[6:0];     // see (RL13)
        if (wr_run) d.scan = wdata[RUN_SCAN_BIT];
        // reading a result clears its flag; a fresh set wins
        d.complete   = (q.complete & ~result_read) | set_c;
        if (start_ev) d.complete = 16'h0;
        d.irq_status = (wr_en && addr == ADDR_IRQ_STATUS) ?
                       (q.irq_status & ~wdata[2:0]) | ev : q.irq_status | ev;
        if (wr_en && addr == ADDR_IRQ_MASK) d.irq_mask = wdata[2:0];
        d.irq    = |(d.irq_status & d.irq_mask);
        d.active = d.state != ST_IDLE;
        d.rdata  = 16'h0;
        if (rd_en) begin
            case (addr)
                ADDR_SEQUENCE_CONTROL: d.rdata = {9'h0, q.ctrl};   // see (RL13)
                ADDR_CONV_STATUS:      d.rdata = {11'h0, q.active, q.counter}; // see (RL7)
                ADDR_VALID_LO:         d.rdata = {8'h0, q.complete[7:0]};
                ADDR_VALID_HI:         d.rdata = {8'h0, q.complete[15:8]};
                ADDR_IRQ_STATUS:       d.rdata = {13'h0, q.irq_status};
                ADDR_IRQ_MASK:         d.rdata = {13'h0, q.irq_mask};
                ADDR_RUN_CONTROL:      d.rdata = {14'h0, q.scan, 1'b0};
                default:               d.rdata = 16'h0;
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clock) begin
        if (reset) begin
            q            <= '0;
            q.state      <= ST_IDLE;
            q.ctrl       <= SEQ_CTRL_RESET[6:0];                   // see (RL3)
            q.irq_status <= IRQ_RESET;
        end else begin
            q <= d;
        end
    end

    assign rdata       = q.rdata;
    assign conv_active = q.active;
    assign result_slot = q.slot;
    assign irq         = q.irq;

    // ==========================================================
    // checks
    property p_write_aborts;
        @(posedge clock) disable iff (reset)
        wr_seq |=> q.state == ST_IDLE && q.counter == 4'h0;
    endproperty
    a_write_aborts: assert property (p_write_aborts) else $error("write did not abort"); // see (RL1)

    property p_reset_len;
        @(posedge clock) $fell(reset) |-> q.ctrl[LEN_MSB:LEN_LSB] == 4'h4;
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset length not four"); // see (RL3)

    property p_len_zero;
        @(posedge clock) disable iff (reset)
        q.ctrl[LEN_MSB:LEN_LSB] == 4'h0 |-> len == 5'h10;
    endproperty
    a_len_zero: assert property (p_len_zero) else $error("zero length not sixteen"); // see (RL2)

    property p_slot_index;
        @(posedge clock) disable iff (reset)
        q.state == ST_CONV && conv_done && !abort_ev && !start_ev && !halted_now
        |=> result_slot.valid && result_slot.index == $past(q.counter);
    endproperty
    a_slot_index: assert property (p_slot_index) else $error("wrong result slot"); // see (RL4)

    property p_nonqueue_bound;
        @(posedge clock) disable iff (reset)
        !queue && q.state == ST_CONV |-> {1'b0, q.counter} < len;
    endproperty
    a_nonqueue_bound: assert property (p_nonqueue_bound) else $error("counter past length"); // see (RL4)

    property p_start_clears;
        @(posedge clock) disable iff (reset)
        start_ev |=> q.counter == 4'h0 && q.state == ST_CONV;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start kept counter"); // see (RL8)

    property p_flag_set;
        @(posedge clock) disable iff (reset)
        result_slot.valid && !start_ev |-> q.complete[result_slot.index];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("complete flag missing"); // see (RL9)

    property p_freeze_now;
        @(posedge clock) disable iff (reset)
        q.state == ST_CONV && halted_now && !abort_ev && !start_ev |=> q.state == ST_HALT;
    endproperty
    a_freeze_now: assert property (p_freeze_now) else $error("no immediate halt"); // see (RL11)

    property p_bit7;
        @(posedge clock) disable iff (reset)
        rd_en && addr == ADDR_SEQUENCE_CONTROL |=> rdata[7] == 1'b0;
    endproperty
    a_bit7: assert property (p_bit7) else $error("bit 7 not zero"); // see (RL13)

    // status read returns the counter of the cycle in which the read was taken
    property p_stat_cnt;
        @(posedge clock) disable iff (reset)
        rd_en && addr == ADDR_CONV_STATUS |=> rdata[3:0] == $past(q.counter);
    endproperty
    a_stat_cnt: assert property (p_stat_cnt) else $error("bad status"); // see (RL7)

    // other control registers abort just like a write here
    property p_other_abort;
        @(posedge clock) disable iff (reset)
        other_ctrl_write && !start_ev |=> q.state == ST_IDLE && q.counter == 4'h0;
    endproperty
    a_other_abort: assert property (p_other_abort) else $error("no abort"); // see (RL8)

    // queue mode keeps the counter across a triggered restart
    property p_queue_keep;
        @(posedge clock) disable iff (reset)
        queue && q.state == ST_IDLE && triggered_conversion && !abort_ev && !start_ev
        |=> q.state == ST_CONV && q.counter == $past(q.counter);
    endproperty
    a_queue_keep: assert property (p_queue_keep) else $error("queue reset"); // see (RL5)

    // the last register is followed by the first
    property p_wrap;
        @(posedge clock) disable iff (reset)
        queue && q.state == ST_CONV && conv_done && q.counter == 4'hf &&
        !abort_ev && !start_ev && !halted_now |=> q.counter == 4'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap"); // see (RL6)

    // a completed length raises the sequence done flag
    property p_seq_end;
        @(posedge clock) disable iff (reset)
        q.state == ST_CONV && conv_done && !abort_ev && !start_ev && !halted_now &&
        q.done_in_seq + 5'h1 == len |=> q.irq_status[IRQ_SEQ_DONE];
    endproperty
    a_seq_end: assert property (p_seq_end) else $error("no seq done"); // see (RL2)

    // finish-then-halt lets the running conversion land, then stops
    property p_finish;
        @(posedge clock) disable iff (reset)
        q.state == ST_CONV && conv_done && freeze && brk_resp == BRK_FINISH &&
        !abort_ev && !start_ev |=> q.state == ST_HALT && result_slot.valid;
    endproperty
    a_finish: assert property (p_finish) else $error("no finish halt"); // see (RL11)

    // while frozen no result is placed
    property p_halt_hold;
        @(posedge clock) disable iff (reset)
        q.state == ST_HALT && freeze && !abort_ev && !start_ev
        |=> q.state == ST_HALT && !result_slot.valid;
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("left halt"); // see (RL11)

    // releasing the breakpoint resumes the sequence
    property p_resume;
        @(posedge clock) disable iff (reset)
        q.state == ST_HALT && !freeze && !abort_ev && !start_ev |=> q.state == ST_CONV;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume"); // see (RL11)

    // a start throws away the valid marks of the previous run
    property p_start_flags;
        @(posedge clock) disable iff (reset)
        start_ev |=> q.complete == 16'h0;
    endproperty
    a_start_flags: assert property (p_start_flags) else $error("flags kept"); // see (RL9)

    // status bits stay until software writes a one to them
    property p_irq_sticky;
        @(posedge clock) disable iff (reset)
        q.irq_status[IRQ_SEQ_DONE] &&
        !(wr_en && addr == ADDR_IRQ_STATUS && wdata[IRQ_SEQ_DONE])
        |=> q.irq_status[IRQ_SEQ_DONE];
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("flag lost");

    c_wrap: cover property (@(posedge clock) disable iff (reset)
        queue && q.counter == 4'hf && conv_done ##1 q.counter == 4'h0);
    c_halt: cover property (@(posedge clock) disable iff (reset) q.state == ST_HALT);
    c_seq_done: cover property (@(posedge clock) disable iff (reset) q.irq_status[IRQ_SEQ_DONE]);
    c_finish: cover property (@(posedge clock) disable iff (reset)
        q.state == ST_CONV && conv_done && freeze && brk_resp == BRK_FINISH);
    c_overrun: cover property (@(posedge clock) disable iff (reset) q.irq_status[IRQ_OVERRUN]);
endmodule

// [core/seq_pkg.sv]
// package: register map, field layout, reset values and enums of the sequence control block
// assumes a single 125 MHz bus clock and a plain strobe register port
package seq_pkg;
    // ==========================================================
    // register map (word offsets on the plain port)
    localparam logic [3:0] ADDR_SEQUENCE_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_CONV_STATUS      = 4'h1;
    localparam logic [3:0] ADDR_VALID_LO         = 4'h2;
    localparam logic [3:0] ADDR_VALID_HI         = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STATUS       = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK         = 4'h5;
    localparam logic [3:0] ADDR_RUN_CONTROL      = 4'h6;
    // ==========================================================
    // sequence_control fields
    localparam int LEN_MSB = 6;
    localparam int LEN_LSB = 3;
    localparam int QUEUE_BIT = 2;
    localparam int RESP_MSB = 1;
    localparam int RESP_LSB = 0;
    localparam logic [7:0] SEQ_CTRL_RESET = 8'h20;   // length 4
    localparam logic [7:0] SEQ_CTRL_WMASK = 8'h7f;   // bit 7 unused
    // run_control fields
    localparam int RUN_START_BIT = 0;
    localparam int RUN_SCAN_BIT  = 1;
    localparam int RUN_ABORT_BIT = 2;
    // irq bits
    localparam int IRQ_SEQ_DONE = 0;
    localparam int IRQ_CONV_DONE = 1;
    localparam int IRQ_OVERRUN = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    typedef enum logic [1:0] {
        BRK_CONTINUE = 2'b00,
        BRK_RESERVED = 2'b01,
        BRK_FINISH   = 2'b10,
        BRK_NOW      = 2'b11
    } freeze_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_HALT = 3'b100
    } seq_state_t;

    // result handed to the result register file
    typedef struct packed {
        logic       valid;
        logic [3:0] index;
    } result_slot_t;

    // decode length field: zero means sixteen
    function automatic logic [4:0] seq_length(input logic [3:0] f);
        seq_length = (f == 4'h0) ? 5'h10 : {1'b0, f};
    endfunction
endpackage

// [testbench/tb_seq_control.sv]
// self-checking bench for the sequence length, result placement and freeze block
// assumes the register map and field layout of seq_pkg; the bench drives every port itself
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module tb_seq_control
    import seq_pkg::*;
;
    // ==========================================================
    // design ports
    logic         clock = 1'b0;
    logic         reset = 1'b1;
    logic [3:0]   addr = 4'h0;
    logic [15:0]  wdata = 16'h0000;
    logic         wr_en = 1'b0;
    logic         rd_en = 1'b0;
    logic [15:0]  rdata;
    logic         other_ctrl_write = 1'b0;
    logic         triggered_conversion = 1'b0;
    logic         conv_done = 1'b0;
    logic [15:0]  result_read = 16'h0000;
    logic         freeze = 1'b0;
    logic         conv_active;
    result_slot_t result_slot;
    logic         irq;
    int           err_total = 0;
    int           checks_done = 0;
    logic [15:0]  got;

    always #4 clock = ~clock;

    seq_control #(.RESULTS(16)) i_seq_control (
        .clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .other_ctrl_write(other_ctrl_write),
        .triggered_conversion(triggered_conversion), .conv_done(conv_done),
        .result_read(result_read), .freeze(freeze), .conv_active(conv_active),
        .result_slot(result_slot), .irq(irq));

    // ==========================================================
    // bus and converter tasks; one idle edge between calls keeps strobes single-driven
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a; wdata <= d; wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        addr <= a; rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic conv(input logic ev, input logic [3:0] idx);
        @(posedge clock);
        conv_done <= 1'b1;
        @(posedge clock);
        conv_done <= 1'b0;
        #1 `CHK("slot_valid", ev, result_slot.valid)
        if (ev) `CHK("slot_index", idx, result_slot.index)
    endtask
    // kind 0 triggered start, 1 write to another control register
    task automatic pulse(input int kind);
        @(posedge clock);
        if (kind == 0) triggered_conversion <= 1'b1; else other_ctrl_write <= 1'b1;
        @(posedge clock);
        triggered_conversion <= 1'b0; other_ctrl_write <= 1'b0;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        summarize();
    end

    // ==========================================================
    // main sequence
    initial begin
        int   lens [3] = '{16, 1, 3};
        int   n;
        logic v;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        rd(ADDR_SEQUENCE_CONTROL); `CHK("ctrl_reset", 16'h0020, got)
        wr(ADDR_SEQUENCE_CONTROL, 16'h00ff);
        rd(ADDR_SEQUENCE_CONTROL); `CHK("ctrl_bit7", 16'h007f, got)
        rd(4'hf); `CHK("unmapped", 16'h0000, got)
        wr(ADDR_IRQ_STATUS, 16'h0007);
        // position mode: each length fills registers 0..L-1, then stops
        foreach (lens[j]) begin
            wr(ADDR_SEQUENCE_CONTROL, {9'h0, lens[j][3:0], 3'h0});
            wr(ADDR_RUN_CONTROL, 16'h0001);
            for (int i = 0; i < lens[j]; i++) conv(1'b1, i[3:0]);
            conv(1'b0, 4'h0);
            rd(ADDR_CONV_STATUS); `CHK("status_end", 16'h0000, got)
        end
        rd(ADDR_VALID_LO); `CHK("flags", 16'h0007, got)
        @(posedge clock) result_read <= 16'h0002;
        @(posedge clock) result_read <= 16'h0000;
        rd(ADDR_VALID_LO); `CHK("flags_read", 16'h0005, got)
        // interrupt: sticky status, mask changes the line, write one clears
        rd(ADDR_IRQ_STATUS); `CHK("irq_status", 16'h0003, got & 16'h0003)
        wr(ADDR_IRQ_MASK, 16'h0007);
        #1 `CHK("irq_on", 1'b1, irq)
        wr(ADDR_IRQ_MASK, 16'h0000);
        #1 `CHK("irq_mask", 1'b0, irq)
        wr(ADDR_IRQ_STATUS, 16'h0007);
        wr(ADDR_IRQ_MASK, 16'h0007);
        rd(ADDR_IRQ_STATUS); `CHK("irq_clear", 16'h0000, got)
        rd(ADDR_IRQ_MASK); `CHK("mask_read", 16'h0007, got)
        `CHK("irq_line", 1'b0, irq)
        // queue mode: counter survives sequence end and a triggered start
        wr(ADDR_SEQUENCE_CONTROL, 16'h0014);
        wr(ADDR_RUN_CONTROL, 16'h0001);
        conv(1'b1, 4'h0);
        conv(1'b1, 4'h1);
        rd(ADDR_CONV_STATUS); `CHK("queue_end", 16'h0002, got)
        `CHK("idle_active", 1'b0, conv_active)
        pulse(0);
        conv(1'b1, 4'h2);
        rd(ADDR_CONV_STATUS); `CHK("queue_run", 16'h0013, got)
        pulse(1);
        rd(ADDR_CONV_STATUS); `CHK("other_write", 16'h0000, got)
        // control write mid-sequence aborts and starts nothing
        wr(ADDR_RUN_CONTROL, 16'h0001);
        conv(1'b1, 4'h0);
        wr(ADDR_SEQUENCE_CONTROL, 16'h0014);
        rd(ADDR_CONV_STATUS); `CHK("ctrl_abort", 16'h0000, got)
        conv(1'b0, 4'h0);
        // queue with scan, length three: only the wrap brings the counter back to zero
        wr(ADDR_SEQUENCE_CONTROL, 16'h001c);
        wr(ADDR_RUN_CONTROL, 16'h0003);
        for (int i = 0; i < 17; i++) conv(1'b1, i[3:0]);
        rd(ADDR_CONV_STATUS); `CHK("wrap", 16'h0011, got)
        rd(ADDR_VALID_HI); `CHK("flags_hi", 16'h00ff, got)
        rd(ADDR_IRQ_STATUS); `CHK("overrun", 16'h0007, got)
        rd(ADDR_RUN_CONTROL); `CHK("scan_read", 16'h0002, got)
        wr(ADDR_RUN_CONTROL, 16'h0004);
        rd(ADDR_CONV_STATUS); `CHK("abort", 16'h0000, got)
        // every breakpoint response, length three
        for (int m = 0; m < 4; m++) begin
            n = 0;
            wr(ADDR_SEQUENCE_CONTROL, {9'h0, 4'h3, 1'b0, m[1:0]});
            wr(ADDR_RUN_CONTROL, 16'h0001);
            @(posedge clock) freeze <= 1'b1;
            for (int k = 0; k < 2; k++) begin
                v = (k == 0) ? (m != 3) : (m < 2);
                conv(v, n[3:0]);
                if (v) n++;
            end
            @(posedge clock) freeze <= 1'b0;
            conv(1'b1, n[3:0]);
        end
        // reset in mid-run brings outputs and the control register back
        `CHK("active_run", 1'b1, conv_active)
        @(posedge clock) reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        #1 `CHK("active_reset", 1'b0, conv_active)
        `CHK("irq_reset", 1'b0, irq)
        rd(ADDR_SEQUENCE_CONTROL); `CHK("ctrl_reset2", 16'h0020, got)
        rd(ADDR_CONV_STATUS); `CHK("status_reset", 16'h0000, got)
        summarize();
    end
endmodule
